// ---- core/lcr_pkg.sv ----
package lcr_pkg;

  // Register offsets on the management register port
  localparam logic [7:0] LCR_OFS_OB0_DEEMPH  = 8'h35;
  localparam logic [7:0] LCR_OFS_OA1_IDLE    = 8'h39;
  localparam logic [7:0] LCR_OFS_IN1_EQ      = 8'h3A;
  localparam logic [7:0] LCR_OFS_OA1_SWING   = 8'h3B;
  localparam logic [7:0] LCR_OFS_OA1_DEEMPH  = 8'h3C;
  localparam logic [7:0] LCR_OFS_IN1_THRESH  = 8'h3D;

  // Values after reset
  localparam logic [7:0] LCR_RST_DEEMPH      = 8'h03;
  localparam logic [7:0] LCR_RST_IDLE        = 8'h00;
  localparam logic [7:0] LCR_RST_EQ          = 8'h20;
  localparam logic [7:0] LCR_RST_SWING       = 8'h03;
  localparam logic [7:0] LCR_RST_THRESH      = 8'h00;
  localparam logic [7:0] LCR_RDATA_UNMAPPED  = 8'h00;

  // De-emphasis fields and level codes
  localparam int         LCR_DEEMPH_STYLE_BIT = 7;
  localparam logic [7:0] LCR_DEEMPH_0P0DB     = 8'h01;
  localparam logic [7:0] LCR_DEEMPH_3P5DB     = 8'hE8;
  localparam logic [7:0] LCR_DEEMPH_6P0DB     = 8'h88;
  localparam logic [7:0] LCR_DEEMPH_9P0DB     = 8'h90;
  localparam logic [7:0] LCR_DEEMPH_12P0DB    = 8'hA0;

  // Idle/rate select fields
  localparam int LCR_IDLE_AUTO_BIT  = 5;
  localparam int LCR_IDLE_MUTE_BIT  = 4;
  localparam int LCR_RATE_AUTO_BIT  = 1;
  localparam int LCR_RATE_HIGH_BIT  = 0;

  // Output swing codes
  localparam logic [6:0] LCR_SWING_600MV   = 7'h03;
  localparam logic [6:0] LCR_SWING_800MV   = 7'h07;
  localparam logic [6:0] LCR_SWING_1000MV  = 7'h0F;
  localparam logic [6:0] LCR_SWING_1200MV  = 7'h1F;
  localparam logic [6:0] LCR_SWING_RSVD    = 7'h3F;

  // Equalization fields
  localparam int LCR_EQ_EN_BIT     = 5;
  localparam int LCR_EQ_GAIN_HI    = 4;
  localparam int LCR_EQ_GAIN_LO    = 3;
  localparam int LCR_EQ_BOOST_HI   = 2;
  localparam int LCR_EQ_BOOST_LO   = 0;

  // Idle threshold fields
  localparam int LCR_THR_DEASSERT_HI = 3;
  localparam int LCR_THR_DEASSERT_LO = 2;
  localparam int LCR_THR_ASSERT_HI   = 1;
  localparam int LCR_THR_ASSERT_LO   = 0;

  // Decoded de-emphasis level
  typedef enum logic [2:0] {
    LCR_DL_0P0DB,
    LCR_DL_3P5DB,
    LCR_DL_6P0DB,
    LCR_DL_9P0DB,
    LCR_DL_12P0DB,
    LCR_DL_UNLISTED
  } lcr_deemph_lvl_e;

endpackage

// ---- core/lcr_regs.sv ----
// Behaviour
// [R1] Bit 7 of each de-emphasis register: 0 compatibility style, 1 enhanced style.
// [R2] De-emphasis byte 01/E8/88/90/A0 gives 0/-3.5/-6/-9/-12 dB.
// [R3] Swing field 03/07/0F/1F gives 600/800/1000/1200 mV; 3F reserved.
// [R4] Idle bit 5 at 0 means manual mute via bit 4; 1 means auto idle.
// [R5] Manual idle: bit 4 at 0 output drives, at 1 output muted.
// [R6] Rate bit 1 at 0 means manual range via bit 0; 1 means auto rate.
// [R7] Manual rate: bit 0 at 0 selects 2.5-3.2, at 1 selects 5.0-6.4 Gbps.
// [R8] Equalization: enable bit 5, gain stage 4:3, boost 2:0; 24 levels.
// [R9] Equalization resets to 20 hex, bypass; listed boost codes pass straight through.
// [R10] Threshold: de-assert in 3:2, assert in 1:0; default code 00.
// [R11] Host writes zero to reserved bits; device stores them without function.
// [R12] Each lane and output has its own copy; writes reach controls at once.
`timescale 1ns/1ps

module lcr_regs
  import lcr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Register port from the management bus engine
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rd_hit,
  // Lane 0 output B de-emphasis
  output logic             out_b_lane0_deemph_enhanced,
  output logic      [6:0]  out_b_lane0_deemphasis_setting,
  output lcr_deemph_lvl_e  out_b_lane0_deemph_level,
  // Lane 1 output A idle and rate
  output logic             out_a_lane1_idle_auto,
  output logic             out_a_lane1_mute,
  output logic             out_a_lane1_signal_detect_en,
  output logic             out_a_lane1_rate_auto,
  output logic             out_a_lane1_rate_high,
  // Lane 1 output A swing and de-emphasis
  output logic      [6:0]  out_a_lane1_output_swing,
  output logic             out_a_lane1_swing_reserved,
  output logic             out_a_lane1_deemph_enhanced,
  output logic      [6:0]  out_a_lane1_deemphasis_setting,
  output lcr_deemph_lvl_e  out_a_lane1_deemph_level,
  // Lane 1 input equalization and idle thresholds
  output logic             in_lane1_eq_enable,
  output logic      [1:0]  in_lane1_gain_stage_field,
  output logic      [2:0]  in_lane1_boost_level_field,
  output logic      [1:0]  in_lane1_idle_deassert_thr,
  output logic      [1:0]  in_lane1_idle_assert_thr
);

  logic [7:0]      ob0_deemph_ff, nxt_ob0_deemph;
  logic [7:0]      oa1_idle_ff,   nxt_oa1_idle;
  logic [7:0]      in1_eq_ff,     nxt_in1_eq;
  logic [7:0]      oa1_swing_ff,  nxt_oa1_swing;
  logic [7:0]      oa1_deemph_ff, nxt_oa1_deemph;
  logic [7:0]      in1_thresh_ff, nxt_in1_thresh;
  logic [7:0]      rdata_ff,      nxt_rdata;
  logic            rd_hit_ff,     nxt_rd_hit;
  logic            ob0_enh_ff,    nxt_ob0_enh;
  lcr_deemph_lvl_e ob0_lvl_ff,    nxt_ob0_lvl;
  logic            oa1_enh_ff,    nxt_oa1_enh;
  lcr_deemph_lvl_e oa1_lvl_ff,    nxt_oa1_lvl;
  logic            idle_auto_ff,  nxt_idle_auto;
  logic            mute_ff,       nxt_mute;
  logic            sig_det_en_ff, nxt_sig_det_en;
  logic            rate_auto_ff,  nxt_rate_auto;
  logic            rate_high_ff,  nxt_rate_high;
  logic            swing_rsv_ff,  nxt_swing_rsv;

  function automatic lcr_deemph_lvl_e deemph_decode(input logic [7:0] code);
    lcr_deemph_lvl_e lvl;
    case (code)
      LCR_DEEMPH_0P0DB:  lvl = LCR_DL_0P0DB;
      LCR_DEEMPH_3P5DB:  lvl = LCR_DL_3P5DB;
      LCR_DEEMPH_6P0DB:  lvl = LCR_DL_6P0DB;
      LCR_DEEMPH_9P0DB:  lvl = LCR_DL_9P0DB;
      LCR_DEEMPH_12P0DB: lvl = LCR_DL_12P0DB;
      default:           lvl = LCR_DL_UNLISTED;
    endcase
    return lvl; // [R2]
  endfunction

  // Register storage: whole byte kept, reserved bits included
  always_comb begin
    nxt_ob0_deemph = ob0_deemph_ff;
    nxt_oa1_idle   = oa1_idle_ff;
    nxt_in1_eq     = in1_eq_ff;
    nxt_oa1_swing  = oa1_swing_ff;
    nxt_oa1_deemph = oa1_deemph_ff;
    nxt_in1_thresh = in1_thresh_ff;
    if (reg_wr_en) begin
      case (reg_addr) // [R11] [R12]
        LCR_OFS_OB0_DEEMPH: nxt_ob0_deemph = reg_wdata;
        LCR_OFS_OA1_IDLE:   nxt_oa1_idle   = reg_wdata;
        LCR_OFS_IN1_EQ:     nxt_in1_eq     = reg_wdata;
        LCR_OFS_OA1_SWING:  nxt_oa1_swing  = reg_wdata;
        LCR_OFS_OA1_DEEMPH: nxt_oa1_deemph = reg_wdata;
        LCR_OFS_IN1_THRESH: nxt_in1_thresh = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ob0_deemph_ff <= LCR_RST_DEEMPH;
      oa1_idle_ff   <= LCR_RST_IDLE;
      in1_eq_ff     <= LCR_RST_EQ; // [R9]
      oa1_swing_ff  <= LCR_RST_SWING;
      oa1_deemph_ff <= LCR_RST_DEEMPH;
      in1_thresh_ff <= LCR_RST_THRESH; // [R10]
    end else begin
      ob0_deemph_ff <= nxt_ob0_deemph;
      oa1_idle_ff   <= nxt_oa1_idle;
      in1_eq_ff     <= nxt_in1_eq;
      oa1_swing_ff  <= nxt_oa1_swing;
      oa1_deemph_ff <= nxt_oa1_deemph;
      in1_thresh_ff <= nxt_in1_thresh;
    end
  end

  // Read-back, one cycle after the read strobe
  always_comb begin
    nxt_rdata  = rdata_ff;
    nxt_rd_hit = rd_hit_ff;
    if (reg_rd_en) begin
      nxt_rd_hit = 1'b1;
      case (reg_addr)
        LCR_OFS_OB0_DEEMPH: nxt_rdata = ob0_deemph_ff;
        LCR_OFS_OA1_IDLE:   nxt_rdata = oa1_idle_ff;
        LCR_OFS_IN1_EQ:     nxt_rdata = in1_eq_ff;
        LCR_OFS_OA1_SWING:  nxt_rdata = oa1_swing_ff;
        LCR_OFS_OA1_DEEMPH: nxt_rdata = oa1_deemph_ff;
        LCR_OFS_IN1_THRESH: nxt_rdata = in1_thresh_ff;
        default: begin
          nxt_rdata  = LCR_RDATA_UNMAPPED;
          nxt_rd_hit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_ff  <= LCR_RDATA_UNMAPPED;
      rd_hit_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rd_hit_ff <= nxt_rd_hit;
    end
  end

  // Decoded controls follow the new register value in the same edge
  always_comb begin
    nxt_ob0_enh   = nxt_ob0_deemph[LCR_DEEMPH_STYLE_BIT]; // [R1]
    nxt_oa1_enh   = nxt_oa1_deemph[LCR_DEEMPH_STYLE_BIT]; // [R1]
    nxt_ob0_lvl   = deemph_decode(nxt_ob0_deemph); // [R2]
    nxt_oa1_lvl   = deemph_decode(nxt_oa1_deemph); // [R2]
    nxt_idle_auto = nxt_oa1_idle[LCR_IDLE_AUTO_BIT]; // [R4]
    // Manual mute only counts while auto idle is off
    nxt_mute      = !nxt_oa1_idle[LCR_IDLE_AUTO_BIT]
                    && nxt_oa1_idle[LCR_IDLE_MUTE_BIT]; // [R4] [R5]
    // Signal detect runs in auto mode and in manual mute
    nxt_sig_det_en = nxt_oa1_idle[LCR_IDLE_AUTO_BIT]
                     || nxt_oa1_idle[LCR_IDLE_MUTE_BIT]; // [R5]
    nxt_rate_auto = nxt_oa1_idle[LCR_RATE_AUTO_BIT]; // [R6]
    nxt_rate_high = !nxt_oa1_idle[LCR_RATE_AUTO_BIT]
                    && nxt_oa1_idle[LCR_RATE_HIGH_BIT]; // [R6] [R7]
    nxt_swing_rsv = (nxt_oa1_swing[6:0] == LCR_SWING_RSVD); // [R3]
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ob0_enh_ff   <= 1'b0;
      oa1_enh_ff   <= 1'b0;
      ob0_lvl_ff   <= LCR_DL_UNLISTED;
      oa1_lvl_ff   <= LCR_DL_UNLISTED;
      idle_auto_ff <= 1'b0;
      mute_ff      <= 1'b0;
      sig_det_en_ff <= 1'b0;
      rate_auto_ff <= 1'b0;
      rate_high_ff <= 1'b0;
      swing_rsv_ff <= 1'b0;
    end else begin
      ob0_enh_ff   <= nxt_ob0_enh;
      oa1_enh_ff   <= nxt_oa1_enh;
      ob0_lvl_ff   <= nxt_ob0_lvl;
      oa1_lvl_ff   <= nxt_oa1_lvl;
      idle_auto_ff <= nxt_idle_auto;
      mute_ff      <= nxt_mute;
      sig_det_en_ff <= nxt_sig_det_en;
      rate_auto_ff <= nxt_rate_auto;
      rate_high_ff <= nxt_rate_high;
      swing_rsv_ff <= nxt_swing_rsv;
    end
  end

  assign reg_rdata                      = rdata_ff;
  assign reg_rd_hit                     = rd_hit_ff;
  assign out_b_lane0_deemph_enhanced    = ob0_enh_ff;
  assign out_b_lane0_deemphasis_setting = ob0_deemph_ff[6:0];
  assign out_b_lane0_deemph_level       = ob0_lvl_ff;
  assign out_a_lane1_idle_auto          = idle_auto_ff;
  assign out_a_lane1_mute               = mute_ff;
  assign out_a_lane1_signal_detect_en   = sig_det_en_ff;
  assign out_a_lane1_rate_auto          = rate_auto_ff;
  assign out_a_lane1_rate_high          = rate_high_ff;
  assign out_a_lane1_output_swing       = oa1_swing_ff[6:0]; // [R3]
  assign out_a_lane1_swing_reserved     = swing_rsv_ff;
  assign out_a_lane1_deemph_enhanced    = oa1_enh_ff;
  assign out_a_lane1_deemphasis_setting = oa1_deemph_ff[6:0];
  assign out_a_lane1_deemph_level       = oa1_lvl_ff;
  assign in_lane1_eq_enable             = in1_eq_ff[LCR_EQ_EN_BIT]; // [R8]
  assign in_lane1_gain_stage_field      = in1_eq_ff[LCR_EQ_GAIN_HI:LCR_EQ_GAIN_LO]; // [R8]
  assign in_lane1_boost_level_field     = in1_eq_ff[LCR_EQ_BOOST_HI:LCR_EQ_BOOST_LO]; // [R8]
  assign in_lane1_idle_deassert_thr     =
    in1_thresh_ff[LCR_THR_DEASSERT_HI:LCR_THR_DEASSERT_LO]; // [R10]
  assign in_lane1_idle_assert_thr       =
    in1_thresh_ff[LCR_THR_ASSERT_HI:LCR_THR_ASSERT_LO]; // [R10]

endmodule

// ---- testbench/lcr_regs_properties.sv ----
`timescale 1ns/1ps
module lcr_regs_chk
  import lcr_pkg::*;
(
  // Clock, reset and register port
  input wire logic            clk,
  input wire logic            rstn,
  input wire logic            reg_wr_en,
  input wire logic            reg_rd_en,
  input wire logic      [7:0] reg_addr,
  input wire logic      [7:0] reg_wdata,
  input wire logic            reg_rd_hit,
  // Decoded controls
  input wire logic            out_b_lane0_deemph_enhanced,
  input wire lcr_deemph_lvl_e out_a_lane1_deemph_level,
  input wire logic            out_a_lane1_idle_auto,
  input wire logic            out_a_lane1_mute,
  input wire logic            out_a_lane1_rate_auto,
  input wire logic            out_a_lane1_rate_high,
  input wire logic      [6:0] out_a_lane1_output_swing,
  input wire logic            out_a_lane1_swing_reserved,
  input wire logic      [5:0] in_lane1_eq_bits,
  input wire logic      [3:0] in_lane1_thr_bits
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_deemph_style: assert property (reg_wr_en && reg_addr == 8'h35 |=>
    {out_b_lane0_deemph_enhanced, 7'h00} == ($past(reg_wdata) & 8'h80)) else $error("style bit");
  a_deemph_level: assert property (
    reg_wr_en && reg_addr == 8'h3C && reg_wdata == 8'hA0 |=>
    out_a_lane1_deemph_level == LCR_DL_12P0DB) else $error("deemphasis level");
  a_swing_rsvd: assert property (out_a_lane1_swing_reserved ==
    (out_a_lane1_output_swing == 7'h3F)) else $error("swing reserved flag");
  a_idle_manual: assert property (
    reg_wr_en && reg_addr == 8'h39 && reg_wdata[5:4] == 2'b01 |=>
    out_a_lane1_mute && !out_a_lane1_idle_auto) else $error("manual mute");
  a_rate_manual: assert property (
    reg_wr_en && reg_addr == 8'h39 && reg_wdata[1:0] == 2'b01 |=>
    out_a_lane1_rate_high && !out_a_lane1_rate_auto) else $error("manual rate");
  a_eq_fields: assert property (reg_wr_en && reg_addr == 8'h3A |=>
    {2'b00, in_lane1_eq_bits} == ($past(reg_wdata) & 8'h3F)) else $error("eq fields");
  a_thr_fields: assert property (reg_wr_en && reg_addr == 8'h3D |=>
    {4'h0, in_lane1_thr_bits} == ($past(reg_wdata) & 8'h0F)) else $error("threshold fields");
  a_rd_hit: assert property (reg_rd_en |=> reg_rd_hit ==
    ($past(reg_addr) inside {8'h35, [8'h39:8'h3D]})) else $error("read hit");
  a_swing_hold: assert property (!(reg_wr_en && reg_addr == 8'h3B) |=>
    $stable(out_a_lane1_output_swing)) else $error("swing changed");
  c_mute: cover property (out_a_lane1_mute);
  c_rsvd: cover property (out_a_lane1_swing_reserved);
  c_miss: cover property (reg_rd_en && reg_addr == 8'h36);
endmodule

bind lcr_regs lcr_regs_chk lcr_regs_chk_inst (.clk, .rstn, .reg_wr_en, .reg_rd_en, .reg_addr,
  .reg_wdata, .reg_rd_hit, .out_b_lane0_deemph_enhanced, .out_a_lane1_deemph_level,
  .out_a_lane1_idle_auto, .out_a_lane1_mute, .out_a_lane1_rate_auto, .out_a_lane1_rate_high,
  .out_a_lane1_output_swing, .out_a_lane1_swing_reserved,
  .in_lane1_eq_bits({in_lane1_eq_enable, in_lane1_gain_stage_field, in_lane1_boost_level_field}),
  .in_lane1_thr_bits({in_lane1_idle_deassert_thr, in_lane1_idle_assert_thr}));

// ---- testbench/lcr_host_model.sv ----
`timescale 1ns/1ps
module lcr_host_model (
  // Clock
  input  wire logic       clk,
  // Register port toward the block
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rd_hit
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d & (a == 8'h39 ? 8'h33 : a == 8'h3A ? 8'h3F : a == 8'h3B ? 8'h7F :
                     a == 8'h3D ? 8'h0F : 8'hFF);
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(negedge clk);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata;
    h = reg_rd_hit;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
  endtask
endmodule

// ---- testbench/tb_lcr_regs.sv ----
`timescale 1ns/1ps
module tb_lcr_regs;
  import lcr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr, wdata, rdata, rd_d;
  logic wr_en, rd_en, rd_hit, rd_h, b0_enh, a1_enh, i_auto, mute;
  logic det_en, r_auto, r_high, rsv, eq_en;
  logic [6:0] b0_set, a1_set, swing;
  lcr_deemph_lvl_e b0_lvl, a1_lvl;
  logic [1:0] gain, thr_d, thr_a;
  logic [2:0] boost;
  int error_cnt = 0;
  int tests_run = 0;
  always #10 clk = ~clk;
  lcr_host_model lcr_host_model_inst (.clk, .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_hit(rd_hit));
  lcr_regs lcr_regs_inst (.clk, .rstn, .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_hit(rd_hit),
    .out_b_lane0_deemph_enhanced(b0_enh), .out_b_lane0_deemphasis_setting(b0_set),
    .out_b_lane0_deemph_level(b0_lvl), .out_a_lane1_idle_auto(i_auto), .out_a_lane1_mute(mute),
    .out_a_lane1_signal_detect_en(det_en), .out_a_lane1_rate_auto(r_auto),
    .out_a_lane1_rate_high(r_high), .out_a_lane1_output_swing(swing),
    .out_a_lane1_swing_reserved(rsv), .out_a_lane1_deemph_enhanced(a1_enh),
    .out_a_lane1_deemphasis_setting(a1_set), .out_a_lane1_deemph_level(a1_lvl),
    .in_lane1_eq_enable(eq_en), .in_lane1_gain_stage_field(gain),
    .in_lane1_boost_level_field(boost), .in_lane1_idle_deassert_thr(thr_d),
    .in_lane1_idle_assert_thr(thr_a));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic t_reset;
    logic [7:0] o [6] = '{8'h35, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D};
    logic [7:0] v [6] = '{8'h03, 8'h00, 8'h20, 8'h03, 8'h03, 8'h00};
    chk("b0 level", {5'h00, LCR_DL_UNLISTED}, {5'h00, b0_lvl});
    for (int i = 0; i < 6; i++) begin
      lcr_host_model_inst.rd(o[i], rd_d, rd_h);
      chk("reset value", v[i], rd_d);
      chk("read hit", 8'h01, {7'h00, rd_h});
    end
  endtask
  task automatic t_deemph;
    logic [7:0] c [5] = '{8'h01, 8'hE8, 8'h88, 8'h90, 8'hA0};
    for (int i = 0; i < 5; i++) begin
      lcr_host_model_inst.wr(8'h35, c[i]);
      lcr_host_model_inst.wr(8'h3C, c[4-i]);
      chk("b0 level", 8'(i), {5'h00, b0_lvl});
      chk("a1 level", 8'(4-i), {5'h00, a1_lvl});
      chk("b0 style", c[i], {b0_enh, b0_set});
      chk("a1 setting", {c[4-i][7], c[4-i][6:0]}, {a1_enh, a1_set});
    end
  endtask
  task automatic t_idle;
    logic [7:0] v [7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h01, 8'h02, 8'h03};
    logic [7:0] e [7] = '{8'h00, 8'h0C, 8'h14, 8'h14, 8'h01, 8'h02, 8'h02};
    for (int i = 0; i < 7; i++) begin
      lcr_host_model_inst.wr(8'h39, v[i]);
      chk("idle rate", e[i], {3'h0, i_auto, mute, det_en, r_auto, r_high});
    end
  endtask
  task automatic t_swing;
    logic [7:0] c [5] = '{8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F};
    for (int i = 0; i < 5; i++) begin
      lcr_host_model_inst.wr(8'h3B, c[i]);
      chk("swing", {c[i][6:0], i == 4}, {swing, rsv});
    end
  endtask
  task automatic t_eq;
    logic [7:0] c [7] = '{8'h2A, 8'h30, 8'h32, 8'h39, 8'h37, 8'h3B, 8'h3D};
    for (int i = 0; i < 7; i++) begin
      lcr_host_model_inst.wr(8'h3A, c[i]);
      chk("eq fields", c[i], {2'b00, eq_en, gain, boost});
      lcr_host_model_inst.rd(8'h3A, rd_d, rd_h);
      chk("eq read", c[i], rd_d);
    end
  endtask
  task automatic t_thr;
    for (int i = 0; i < 16; i++) begin
      lcr_host_model_inst.wr(8'h3D, 8'(i));
      chk("threshold", 8'(i), {4'h0, thr_d, thr_a});
    end
  endtask
  task automatic t_unmapped;
    lcr_host_model_inst.wr(8'h36, 8'h5A);
    lcr_host_model_inst.rd(8'h36, rd_d, rd_h);
    chk("unmapped read", 8'h00, {rd_d[7:1], rd_h | rd_d[0]});
    // Unmapped write must leave the last threshold value in place
    lcr_host_model_inst.rd(8'h3D, rd_d, rd_h);
    chk("unmapped write ignored", 8'h0F, rd_d);
    @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    t_reset();
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_deemph();
    t_idle();
    t_swing();
    t_eq();
    t_thr();
    t_unmapped();
    finish_test();
  end
  initial begin
    #50us;
    error_cnt++;
    finish_test();
  end
endmodule
